/* File: rtl/bpmn_pkg.sv */
package bpmn_pkg;

    // ----------------------------------------
    // Timebase
    // ----------------------------------------
    localparam int BPMN_CLK_PERIOD_NS = 40;
    localparam int BPMN_TICK_PERIOD_NS = 1000000;  // One millisecond
    localparam int BPMN_TICK_CYCLES = BPMN_TICK_PERIOD_NS / BPMN_CLK_PERIOD_NS;

    // ----------------------------------------
    // Press timing, in milliseconds
    // ----------------------------------------
    localparam int BPMN_SHORT_MIN_MS = 100;
    localparam int BPMN_LONG_MS = 3000;
    localparam int BPMN_REPEAT_MS = 200;

    // ----------------------------------------
    // Widths and button indices
    // ----------------------------------------
    localparam int BPMN_NUM_BTN = 6;
    localparam int BPMN_HOLD_W = 12;
    localparam int BPMN_REP_W = 8;
    localparam int BPMN_TICK_W = 16;
    localparam int BPMN_MENU_W = 4;
    localparam int BPMN_LINE_W = 16;
    localparam int BPMN_COL_W = 4;
    localparam int BTN_UP = 0;
    localparam int BTN_DOWN = 1;
    localparam int BTN_LEFT = 2;
    localparam int BTN_RIGHT = 3;
    localparam int BTN_ESC = 4;
    localparam int BTN_OK = 5;

    localparam logic [BPMN_HOLD_W-1:0] BPMN_HOLD_SHORT = BPMN_HOLD_W'(BPMN_SHORT_MIN_MS);
    localparam logic [BPMN_HOLD_W-1:0] BPMN_HOLD_LONG = BPMN_HOLD_W'(BPMN_LONG_MS);
    localparam logic [BPMN_REP_W-1:0] BPMN_REP_LAST = BPMN_REP_W'(BPMN_REPEAT_MS - 1);

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [BPMN_MENU_W-1:0] BPMN_RST_MENU = 4'h0;
    localparam logic [BPMN_LINE_W-1:0] BPMN_RST_LINE = 16'h0000;
    localparam logic [BPMN_COL_W-1:0] BPMN_RST_COL = 4'h0;

    typedef enum logic [0:0] {
        BPMN_SCR_MENU = 1'b0,
        BPMN_SCR_LADDER = 1'b1
    } bpmn_screen_t;

endpackage

/* File: rtl/bpmn_navigator.sv */
// Behaviour
// - Held 0.1 s to under 3 s: short
// - Held 3 s or more: long
// - Menu short up: cursor up, stop at first
// - Menu short down: cursor down, stop at last
// - Menu up/down held: step repeatedly
// - Menu short OK: execute selected entry
// - Menu short escape: back to caller
// - OK while escape held: menu top
// - Ladder short up: line up within rung
// - Ladder long up: previous rung top line
// - Ladder short down: line down, stop at end
// - Ladder long down: next rung top line
// - Ladder short left: one left, stop edge
// - Ladder long left: jump to left edge
// - Ladder short right: one right, stop edge
// - Ladder long right: jump to right edge
// - Ladder short OK: toggle contact only
// - Ladder long OK: show parameter details
// - Ladder short escape: leave ladder monitor
`timescale 1ns/100ps
module bpmn_navigator
    import bpmn_pkg::*;
#(
    parameter int TICK_CYCLES = BPMN_TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic btnUp,
    input wire logic btnDown,
    input wire logic btnLeft,
    input wire logic btnRight,
    input wire logic btnEsc,
    input wire logic btnOk,
    input wire logic ladderEnter,
    input wire logic [BPMN_MENU_W-1:0] menuLastIdx,
    input wire logic [BPMN_LINE_W-1:0] rungTopLine,
    input wire logic [BPMN_LINE_W-1:0] prevRungTop,
    input wire logic [BPMN_LINE_W-1:0] nextRungTop,
    input wire logic [BPMN_LINE_W-1:0] ladderLastLine,
    input wire logic [BPMN_COL_W-1:0] lineRightCol,
    input wire logic elemIsContact,
    output logic screenIsLadder,
    output logic [BPMN_MENU_W-1:0] menuCursor,
    output logic [BPMN_LINE_W-1:0] ladderLine,
    output logic [BPMN_COL_W-1:0] ladderCol,
    output logic [BPMN_NUM_BTN-1:0] shortPress,
    output logic [BPMN_NUM_BTN-1:0] longPress,
    output logic menuExecute,
    output logic menuBack,
    output logic menuTop,
    output logic contactToggle,
    output logic showDetail,
    output logic ladderExit
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [BPMN_TICK_W-1:0] tickCnt;
        logic [BPMN_NUM_BTN-1:0] btnPrev;
        logic [BPMN_NUM_BTN-1:0][BPMN_HOLD_W-1:0] holdMs;
        logic [BPMN_REP_W-1:0] repMs;
        logic escCombo;
        bpmn_screen_t screen;
        logic [BPMN_MENU_W-1:0] menuCur;
        logic [BPMN_LINE_W-1:0] line;
        logic [BPMN_COL_W-1:0] col;
        logic [BPMN_NUM_BTN-1:0] shortP;
        logic [BPMN_NUM_BTN-1:0] longP;
        logic execP;
        logic backP;
        logic topP;
        logic toggleP;
        logic detailP;
        logic exitP;
    } bpmn_state_t;

    localparam logic [BPMN_TICK_W-1:0] TICK_LAST = BPMN_TICK_W'(TICK_CYCLES - 1);

    bpmn_state_t q;
    bpmn_state_t d;
    logic [BPMN_NUM_BTN-1:0] btnNow;
    logic [BPMN_NUM_BTN-1:0] released;
    logic [BPMN_NUM_BTN-1:0] shortEv;
    logic [BPMN_NUM_BTN-1:0] longEv;
    logic [1:0] repStep;
    logic tick;
    logic comboOk;
    logic stepUp;
    logic stepDown;

    assign btnNow = {btnOk, btnEsc, btnRight, btnLeft, btnDown, btnUp};

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        d = q;
        tick = (q.tickCnt == TICK_LAST);
        released = q.btnPrev & ~btnNow;
        shortEv = '0;
        longEv = '0;
        repStep = '0;
        d.btnPrev = btnNow;
        d.tickCnt = tick ? '0 : q.tickCnt + 16'h0001;
        // Millisecond hold counters saturate at the long threshold
        for (int i = 0; i < BPMN_NUM_BTN; i++) begin
            shortEv[i] = released[i] && q.holdMs[i] >= BPMN_HOLD_SHORT
                && q.holdMs[i] < BPMN_HOLD_LONG;
            longEv[i] = released[i] && q.holdMs[i] == BPMN_HOLD_LONG;
            if (!btnNow[i]) begin
                d.holdMs[i] = '0;
            end else if (tick && q.holdMs[i] != BPMN_HOLD_LONG) begin
                d.holdMs[i] = q.holdMs[i] + 12'h001;
            end
        end
        // Repeat: one step on reaching long, then one per interval
        for (int i = 0; i < 2; i++) begin
            repStep[i] = tick && btnNow[i] && ((q.holdMs[i] == BPMN_HOLD_LONG - 12'h001)
                || (q.holdMs[i] == BPMN_HOLD_LONG && q.repMs == BPMN_REP_LAST));
        end
        if (tick) begin
            if ((btnUp && q.holdMs[BTN_UP] == BPMN_HOLD_LONG)
                    || (btnDown && q.holdMs[BTN_DOWN] == BPMN_HOLD_LONG)) begin
                d.repMs = (q.repMs == BPMN_REP_LAST) ? '0 : q.repMs + 8'h01;
            end else begin
                d.repMs = '0;
            end
        end
        d.shortP = shortEv;
        d.longP = longEv;
        d.execP = 1'b0;
        d.backP = 1'b0;
        d.topP = 1'b0;
        d.toggleP = 1'b0;
        d.detailP = 1'b0;
        d.exitP = 1'b0;
        // OK while escape is down; the later escape release is swallowed
        comboOk = shortEv[BTN_OK] && btnEsc;
        if (comboOk) begin
            d.escCombo = 1'b1;
        end else if (!btnEsc) begin
            d.escCombo = 1'b0;
        end
        stepUp = shortEv[BTN_UP] || repStep[BTN_UP];
        stepDown = shortEv[BTN_DOWN] || repStep[BTN_DOWN];
        unique case (q.screen)
            BPMN_SCR_MENU: begin
                if (ladderEnter) begin
                    d.screen = BPMN_SCR_LADDER;
                    d.line = BPMN_RST_LINE;
                    d.col = BPMN_RST_COL;
                end else begin
                    if (stepUp && q.menuCur != '0) begin
                        d.menuCur = q.menuCur - 4'h1;
                    end else if (stepDown && q.menuCur < menuLastIdx) begin
                        d.menuCur = q.menuCur + 4'h1;
                    end
                    if (shortEv[BTN_OK] && !comboOk) begin
                        d.execP = 1'b1;
                    end
                    if (shortEv[BTN_ESC] && !q.escCombo) begin
                        d.backP = 1'b1;
                    end
                end
            end
            BPMN_SCR_LADDER: begin
                // Vertical moves
                if (shortEv[BTN_UP] && q.line != rungTopLine) begin
                    d.line = q.line - 16'h0001;
                end else if (longEv[BTN_UP]) begin
                    d.line = prevRungTop;
                end else if (shortEv[BTN_DOWN] && q.line != ladderLastLine) begin
                    d.line = q.line + 16'h0001;
                end else if (longEv[BTN_DOWN]) begin
                    d.line = nextRungTop;
                end
                // Horizontal moves
                if (shortEv[BTN_LEFT] && q.col != '0) begin
                    d.col = q.col - 4'h1;
                end else if (longEv[BTN_LEFT]) begin
                    d.col = '0;
                end else if (shortEv[BTN_RIGHT] && q.col != lineRightCol) begin
                    d.col = q.col + 4'h1;
                end else if (longEv[BTN_RIGHT]) begin
                    d.col = lineRightCol;
                end
                d.toggleP = shortEv[BTN_OK] && !comboOk && elemIsContact;
                d.detailP = longEv[BTN_OK];
                if (shortEv[BTN_ESC] && !q.escCombo) begin
                    d.screen = BPMN_SCR_MENU;
                    d.exitP = 1'b1;
                end
            end
        endcase
        // The combination wins over the screen and menu cursor the screen logic chose
        if (comboOk) begin
            d.screen = BPMN_SCR_MENU;
            d.menuCur = BPMN_RST_MENU;
            d.topP = 1'b1;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{screen: BPMN_SCR_MENU, menuCur: BPMN_RST_MENU, line: BPMN_RST_LINE,
                col: BPMN_RST_COL, default: '0};
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign screenIsLadder = (q.screen == BPMN_SCR_LADDER);
    assign menuCursor = q.menuCur;
    assign ladderLine = q.line;
    assign ladderCol = q.col;
    assign shortPress = q.shortP;
    assign longPress = q.longP;
    assign menuExecute = q.execP;
    assign menuBack = q.backP;
    assign menuTop = q.topP;
    assign contactToggle = q.toggleP;
    assign showDetail = q.detailP;
    assign ladderExit = q.exitP;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_short_class: assert property ($fell(btnOk) && $past(btnOk) && q.holdMs[BTN_OK] >= 12'd100
        && q.holdMs[BTN_OK] < 12'd3000 |=> shortPress[BTN_OK] && !longPress[BTN_OK])
        else $error("short press not classified");
    a_long_class: assert property ($fell(btnDown) && q.holdMs[BTN_DOWN] == 12'd3000
        |=> longPress[BTN_DOWN] && !shortPress[BTN_DOWN])
        else $error("long press not classified");
    a_glitch_drop: assert property ($fell(btnLeft) && q.holdMs[BTN_LEFT] < 12'd100
        |=> !shortPress[BTN_LEFT] && !longPress[BTN_LEFT] && $stable(ladderCol))
        else $error("brief press produced an event");
    a_menu_top: assert property (!screenIsLadder && menuCursor == 4'h0 && !stepDown && !ladderEnter
        && !btnOk |=> menuCursor == 4'h0)
        else $error("menu cursor moved above first entry");
    a_menu_last: assert property (!screenIsLadder && menuCursor == menuLastIdx && !stepUp
        && !comboOk && $stable(menuLastIdx) |=> menuCursor == $past(menuCursor))
        else $error("menu cursor moved past last entry");
    a_menu_repeat: assert property (!screenIsLadder && repStep[BTN_UP] && menuCursor != 4'h0
        && !ladderEnter && !comboOk |=> menuCursor == $past(menuCursor) - 4'h1)
        else $error("held up did not repeat");
    a_menu_exec: assert property (!screenIsLadder && !ladderEnter && shortEv[BTN_OK] && !btnEsc
        |=> menuExecute ##1 !menuExecute)
        else $error("menu OK did not execute");
    a_menu_back: assert property (!screenIsLadder && !ladderEnter && shortEv[BTN_ESC]
        && !q.escCombo |=> menuBack)
        else $error("menu escape did not go back");
    a_combo_top: assert property (shortEv[BTN_OK] && btnEsc
        |=> menuTop && !screenIsLadder && menuCursor == 4'h0 && !menuExecute)
        else $error("escape plus OK did not reach menu top");
    a_ladder_rung: assert property (screenIsLadder && longEv[BTN_UP] && !comboOk
        |=> ladderLine == $past(prevRungTop))
        else $error("long up missed previous rung top");
    a_ladder_up: assert property (screenIsLadder && shortEv[BTN_UP] && !comboOk
        |=> ladderLine == ($past(ladderLine == rungTopLine) ? $past(ladderLine)
        : $past(ladderLine) - 16'h0001))
        else $error("short up moved wrongly");
    a_ladder_down: assert property (screenIsLadder && shortEv[BTN_DOWN] && !shortEv[BTN_UP]
        && !longEv[BTN_UP] && !comboOk
        |=> ladderLine == ($past(ladderLine == ladderLastLine) ? $past(ladderLine)
        : $past(ladderLine) + 16'h0001))
        else $error("short down moved wrongly");
    a_ladder_next: assert property (screenIsLadder && longEv[BTN_DOWN] && !shortEv[BTN_UP]
        && !longEv[BTN_UP] && !comboOk |=> ladderLine == $past(nextRungTop))
        else $error("long down missed next rung top");
    a_ladder_left: assert property (screenIsLadder && shortEv[BTN_LEFT]
        |=> ladderCol == ($past(ladderCol == 4'h0) ? $past(ladderCol)
        : $past(ladderCol) - 4'h1))
        else $error("short left moved wrongly");
    a_ladder_home: assert property (screenIsLadder && longEv[BTN_LEFT]
        |=> ladderCol == 4'h0)
        else $error("long left missed left edge");
    a_ladder_right: assert property (screenIsLadder && shortEv[BTN_RIGHT] && !shortEv[BTN_LEFT]
        && !longEv[BTN_LEFT]
        |=> ladderCol == ($past(ladderCol == lineRightCol) ? $past(ladderCol)
        : $past(ladderCol) + 4'h1))
        else $error("short right moved wrongly");
    a_ladder_detail: assert property (screenIsLadder && longEv[BTN_OK]
        |=> showDetail)
        else $error("long OK did not show details");
    a_ladder_edge: assert property (screenIsLadder && longEv[BTN_RIGHT] && !longEv[BTN_LEFT]
        && !shortEv[BTN_LEFT] |=> ladderCol == $past(lineRightCol))
        else $error("long right missed right edge");
    a_ladder_toggle: assert property (screenIsLadder && shortEv[BTN_OK] && !btnEsc
        |=> contactToggle == $past(elemIsContact))
        else $error("contact toggle wrong");
    a_ladder_exit: assert property (screenIsLadder && shortEv[BTN_ESC] && !q.escCombo
        |=> !screenIsLadder && ladderExit)
        else $error("escape did not leave ladder monitor");

endmodule // bpmn_navigator

/* File: test/bpmn_operator.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Front-panel operator model
// ----------------------------------------
module bpmn_operator #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic core_clk,
    output logic btnUp,
    output logic btnDown,
    output logic btnLeft,
    output logic btnRight,
    output logic btnEsc,
    output logic btnOk
);
    logic [5:0] held = 6'h00;

    // Levels come straight from the held mask; the panel is already debounced
    assign {btnOk, btnEsc, btnRight, btnLeft, btnDown, btnUp} = held;

    // Keep one button down with no release, as escape is held for the top jump
    task automatic hold(input int idx);
        @(posedge core_clk);
        held[idx] <= 1'b1;
    endtask

    // Press for whole milliseconds; levels only move just after a rising edge
    task automatic press(input int idx, input int ms);
        @(posedge core_clk);
        held[idx] <= 1'b1;
        repeat (ms * TICK_CYCLES) @(posedge core_clk);
        held[idx] <= 1'b0;
    endtask
endmodule // bpmn_operator

/* File: test/bpmn_navigator_tb_top.sv */
`timescale 1ns/100ps
module bpmn_navigator_tb_top
    import bpmn_pkg::*;
;
    localparam int TC = 4;
    localparam logic [5:0] A_EXEC = 6'h20, A_BACK = 6'h10, A_TOP = 6'h08;
    localparam logic [5:0] A_TOG = 6'h04, A_DET = 6'h02, A_EXIT = 6'h01;
    logic core_clk = 1'b0, rst_n = 1'b0, ladderEnter = 1'b0, elemIsContact = 1'b0, clr = 1'b0;
    logic btnUp, btnDown, btnLeft, btnRight, btnEsc, btnOk, screenIsLadder;
    logic menuExecute, menuBack, menuTop, contactToggle, showDetail, ladderExit;
    logic [3:0] menuLastIdx = 4'h2, menuCursor, ladderCol, mc;
    logic [15:0] ladderLine, rungTopLine, ln;
    logic [5:0] shortPress, longPress;
    logic [17:0] seen;
    logic ec;
    int n_tests = 0, err_count = 0;

    // Two rungs, lines 0..3 and 4..5; the rung top follows the cursor line
    assign rungTopLine = {ladderLine[15:2], 2'h0};

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    bpmn_operator #(.TICK_CYCLES(TC)) i_bpmn_operator (.core_clk(core_clk), .btnUp(btnUp),
        .btnDown(btnDown), .btnLeft(btnLeft), .btnRight(btnRight), .btnEsc(btnEsc), .btnOk(btnOk));

    bpmn_navigator #(.TICK_CYCLES(TC)) i_bpmn_navigator (.core_clk(core_clk), .rst_n(rst_n),
        .btnUp(btnUp), .btnDown(btnDown), .btnLeft(btnLeft), .btnRight(btnRight),
        .btnEsc(btnEsc), .btnOk(btnOk), .ladderEnter(ladderEnter), .menuLastIdx(menuLastIdx),
        .rungTopLine(rungTopLine), .prevRungTop(16'h0000), .nextRungTop(16'h0004),
        .ladderLastLine(16'h0005), .lineRightCol(4'h5), .elemIsContact(elemIsContact),
        .screenIsLadder(screenIsLadder), .menuCursor(menuCursor), .ladderLine(ladderLine),
        .ladderCol(ladderCol), .shortPress(shortPress), .longPress(longPress),
        .menuExecute(menuExecute), .menuBack(menuBack), .menuTop(menuTop),
        .contactToggle(contactToggle), .showDetail(showDetail), .ladderExit(ladderExit));

    // Sticky event collector, so a one-cycle pulse cannot slip past a check
    always @(posedge core_clk) begin
        seen <= clr ? 18'h00000 : (seen | {menuExecute, menuBack, menuTop, contactToggle,
            showDetail, ladderExit, longPress, shortPress});
    end

    // ----------------------------------------
    // Checking and expectation helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Menu step with a stop at either end of the list
    function automatic logic [3:0] step(input logic [3:0] c, input logic [3:0] last, input bit dn);
        if (dn) return (c == last) ? c : c + 4'h1;
        return (c == 4'h0) ? c : c - 4'h1;
    endfunction

    // Short hold well clear of both thresholds, allowing one tick of quantisation
    function automatic int sms();
        return 110 + $urandom_range(90, 0);
    endfunction

    // One press, then the class of the press and the action pulses it raised
    task automatic bpress(input int idx, input int ms, input logic [5:0] act);
        logic [17:0] exp;
        exp = {act, 12'h000};
        if (ms >= BPMN_LONG_MS) exp[6 + idx] = 1'b1;
        else if (ms >= BPMN_SHORT_MIN_MS) exp[idx] = 1'b1;
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        i_bpmn_operator.press(idx, ms);
        repeat (3) @(posedge core_clk);
        check({14'h0000, seen}, {14'h0000, exp});
    endtask

    // Screen and both cursors at once
    task automatic st(input logic scr, input logic [3:0] m, input logic [15:0] l, input logic [3:0] c);
        check({7'h00, screenIsLadder, menuCursor, ladderLine, ladderCol}, {7'h00, scr, m, l, c});
    endtask

    task automatic enter();
        @(posedge core_clk);
        ladderEnter <= 1'b1;
        @(posedge core_clk);
        ladderEnter <= 1'b0;
        @(posedge core_clk);
        st(1'b1, mc, 16'h0000, 4'h0);
    endtask

    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h9fede9c2));
        menuLastIdx <= 4'h2 + 4'($urandom_range(4, 0));
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        mc = 4'h0;
        st(1'b0, mc, 16'h0000, 4'h0);
        bpress(BTN_DOWN, 40 + $urandom_range(40, 0), 6'h00);
        st(1'b0, mc, 16'h0000, 4'h0);
        for (int k = 0; k < 5; k++) begin
            bpress(BTN_DOWN, sms(), 6'h00);
            mc = step(mc, menuLastIdx, 1'b1);
            st(1'b0, mc, 16'h0000, 4'h0);
        end
        // Hold up past the long mark plus one repeat interval: two steps
        bpress(BTN_UP, BPMN_LONG_MS + BPMN_REPEAT_MS + 10, 6'h00);
        mc = mc - 4'h2;
        st(1'b0, mc, 16'h0000, 4'h0);
        for (int k = 0; k < 8; k++) begin
            bpress(BTN_UP, sms(), 6'h00);
            mc = step(mc, menuLastIdx, 1'b0);
            st(1'b0, mc, 16'h0000, 4'h0);
        end
        // Same for down from the first entry
        bpress(BTN_DOWN, BPMN_LONG_MS + BPMN_REPEAT_MS + 50, 6'h00);
        mc = 4'h2;
        st(1'b0, mc, 16'h0000, 4'h0);
        bpress(BTN_OK, sms(), A_EXEC);
        bpress(BTN_ESC, sms(), A_BACK);
        $display("menu test done");
        enter();
        ln = 16'h0000;
        bpress(BTN_UP, sms(), 6'h00);
        st(1'b1, mc, 16'h0000, 4'h0);
        bpress(BTN_DOWN, sms(), 6'h00);
        st(1'b1, mc, 16'h0001, 4'h0);
        bpress(BTN_UP, sms(), 6'h00);
        st(1'b1, mc, 16'h0000, 4'h0);
        bpress(BTN_DOWN, sms(), 6'h00);
        bpress(BTN_DOWN, 3050, 6'h00);
        st(1'b1, mc, 16'h0004, 4'h0);
        bpress(BTN_DOWN, sms(), 6'h00);
        bpress(BTN_DOWN, sms(), 6'h00);
        st(1'b1, mc, 16'h0005, 4'h0);
        bpress(BTN_UP, 3050, 6'h00);
        st(1'b1, mc, 16'h0000, 4'h0);
        bpress(BTN_RIGHT, 3050, 6'h00);
        st(1'b1, mc, 16'h0000, 4'h5);
        bpress(BTN_RIGHT, sms(), 6'h00);
        st(1'b1, mc, 16'h0000, 4'h5);
        bpress(BTN_LEFT, sms(), 6'h00);
        st(1'b1, mc, 16'h0000, 4'h4);
        bpress(BTN_LEFT, 3050, 6'h00);
        st(1'b1, mc, 16'h0000, 4'h0);
        bpress(BTN_LEFT, sms(), 6'h00);
        st(1'b1, mc, 16'h0000, 4'h0);
        for (int k = 0; k < 2; k++) begin
            ec = 1'($urandom_range(1, 0)) ^ k[0];
            elemIsContact <= ec;
            bpress(BTN_OK, sms(), ec ? A_TOG : 6'h00);
        end
        elemIsContact <= 1'b1;
        bpress(BTN_OK, sms(), A_TOG);
        elemIsContact <= 1'b0;
        bpress(BTN_OK, sms(), 6'h00);
        bpress(BTN_OK, 3050, A_DET);
        // Escape held while OK is tapped, then escape let go with no back action
        i_bpmn_operator.hold(BTN_ESC);
        bpress(BTN_OK, sms(), A_TOP);
        check({27'h0, screenIsLadder, menuCursor}, {27'h0, 1'b0, 4'h0});
        bpress(BTN_ESC, sms(), 6'h00);
        mc = 4'h0;
        enter();
        bpress(BTN_ESC, sms(), A_EXIT);
        check({31'h0, screenIsLadder}, 32'h0);
        $display("ladder test done");
        summarize();
    end
endmodule // bpmn_navigator_tb_top
